// *** pkg/scc_pkg.sv ***
package scc_pkg;

  // Register offsets on the serial port
  localparam logic [7:0] REG_PRESCALE  = 8'h02;
  localparam logic [7:0] REG_SPAN_GATE = 8'h0D;
  localparam logic [7:0] REG_COMMIT    = 8'h3F;

  // Values held before the stored image is loaded
  localparam logic [7:0] PRESCALE_RST  = 8'h00;
  localparam logic [7:0] SPAN_GATE_RST = 8'h00;

  // Largest divider exponent honoured
  localparam logic [3:0] EXP_MAX = 4'h8;

  // One oscillator cycle is two system clocks (one per output level)
  localparam int CLK_PER_OSC     = 2;
  localparam int STARTUP_OSC_CYC = 512;
  localparam int STARTUP_CLK     = STARTUP_OSC_CYC * CLK_PER_OSC;

  // Dither sweep: fastest rate code 1 spans 2048 oscillator cycles
  localparam int DITHER_BASE_OSC  = 2048;
  localparam int DITHER_STEPS     = 512;
  localparam int DITHER_STEP_BASE =
    DITHER_BASE_OSC * CLK_PER_OSC / DITHER_STEPS;
  localparam int OFFSET_W         = 12;

  // Serial port sequencer states
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ADDR = 8'h02,
    S_ACKA = 8'h04,
    S_CMD  = 8'h08,
    S_ACKC = 8'h10,
    S_DATA = 8'h20,
    S_RD   = 8'h40,
    S_RACK = 8'h80
  } scc_i2c_st_t;

  // Divider and dither-rate register layout
  typedef struct packed {
    logic       dither_rate_hi;
    logic       dither_rate_lo;
    logic       idle_output_level;
    logic       rsvd;
    logic [3:0] prescale_exp;
  } scc_pres_t;

  // Span, gate and slave-bits register layout
  typedef struct packed {
    logic       dither_span_hi;
    logic       dither_span_lo;
    logic       sw_gate_n;
    logic       rsvd;
    logic       nv_write_defer;
    logic [2:0] slave_sel;
  } scc_span_t;

  // Image kept in nonvolatile memory
  typedef struct packed {
    scc_pres_t pres;
    scc_span_t span;
  } scc_nv_t;

  // Whole state of the block
  typedef struct packed {
    logic                       loaded;
    scc_pres_t                  pres;
    scc_span_t                  span;
    scc_i2c_st_t                i2c;
    logic [3:0]                 bitc;
    logic [7:0]                 sh;
    logic [7:0]                 ptr;
    logic                       rw;
    logic                       scl_q;
    logic                       sda_q;
    logic                       sda_oe;
    logic                       nv_write;
    logic [7:0]                 div_cnt;
    logic                       phase;
    logic                       run;
    logic [10:0]                boot_cnt;
    logic                       booted;
    logic                       clk_pin;
    logic                       clk_pin_oe;
    logic [4:0]                 dcnt;
    logic [8:0]                 dph;
    logic signed [OFFSET_W-1:0] doff;
  } scc_state_t;

endpackage

// *** hdl/scc_config_regs.sv ***
module scc_config_regs #(
  parameter logic [3:0] SLAVE_ADDR_HI = 4'h5  // Arbitrary value
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_out,
  input  wire logic                   dither_enable_pin_in,
  input  wire logic                   output_enable_pin_in,
  input  wire logic                   power_down_pin_n_in,
  input  wire scc_pkg::scc_nv_t       nv_image_in,
  output scc_pkg::scc_nv_t            nv_image_out,
  output logic                        nv_write_out,
  output logic                        clk_pin_out,
  output logic                        clk_pin_oe_out,
  output logic signed [scc_pkg::OFFSET_W-1:0] dither_offset_out
);
  import scc_pkg::*;

  // Reserved slave address groups cannot be served
  if (SLAVE_ADDR_HI == 4'h0 || SLAVE_ADDR_HI == 4'hF) begin : g_chk
    $error("slave address high bits fall in a reserved group");
  end

  scc_state_t st;
  scc_state_t nx;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       wr_pres;
  logic       wr_span;
  logic       commit;
  logic [7:0] rd_byte;
  logic [3:0] eff_exp;
  logic [7:0] mask;
  logic       tick;
  logic       active;
  logic       dith_on;
  logic [1:0] rate;
  logic [1:0] span;
  logic [4:0] lim;
  logic [7:0] tri_v;

  // Bus edge and condition detection
  assign rise  = scl_in & ~st.scl_q;
  assign fall  = ~scl_in & st.scl_q;
  assign start = scl_in & st.scl_q & st.sda_q & ~sda_in;
  assign stop  = scl_in & st.scl_q & ~st.sda_q & sda_in;

  // Decoded settings
  assign rate    = {st.pres.dither_rate_hi, st.pres.dither_rate_lo};
  assign span    = {st.span.dither_span_hi, st.span.dither_span_lo};
  assign eff_exp = (st.pres.prescale_exp > EXP_MAX) ? EXP_MAX
                   : st.pres.prescale_exp;
  assign mask    = 8'((9'h001 << eff_exp) - 9'h001);
  assign tick    = (st.div_cnt & mask) == mask;
  assign active  = power_down_pin_n_in & st.booted
                   & (~st.span.sw_gate_n | output_enable_pin_in);
  assign dith_on = dither_enable_pin_in & (rate != 2'h0);
  assign lim     = 5'((6'(DITHER_STEP_BASE) << (rate - 2'h1)) - 6'h01);
  assign tri_v   = st.dph[8] ? ~st.dph[7:0] : st.dph[7:0];
  assign rd_byte = (st.ptr == REG_PRESCALE)  ? st.pres
                 : (st.ptr == REG_SPAN_GATE) ? st.span : 8'h00;

  // Next-state logic
  always_comb begin
    nx       = st;
    wr_pres  = 1'b0;
    wr_span  = 1'b0;
    commit   = 1'b0;
    nx.scl_q = scl_in;
    nx.sda_q = sda_in;

    // Stored image taken on the first cycle after reset
    if (!st.loaded) begin
      nx.loaded    = 1'b1;
      nx.pres      = nv_image_in.pres;
      nx.span      = nv_image_in.span;
      nx.pres.rsvd = 1'b0;
      nx.span.rsvd = 1'b0;
    end

    // Serial port byte engine
    case (st.i2c)
      S_IDLE: begin
      end
      S_ADDR, S_CMD, S_DATA: begin
        if (rise) begin
          nx.sh   = {st.sh[6:0], sda_in};
          nx.bitc = st.bitc + 4'h1;
        end else if (fall && st.bitc == 4'h8) begin
          nx.bitc = 4'h0;
          if (st.i2c == S_ADDR) begin
            if (st.sh[7:1] == {SLAVE_ADDR_HI, st.span.slave_sel}) begin
              nx.sda_oe = 1'b1;
              nx.rw     = st.sh[0];
              nx.i2c    = S_ACKA;
            end else begin
              nx.i2c = S_IDLE;
            end
          end else if (st.i2c == S_CMD) begin
            nx.ptr    = st.sh;
            nx.sda_oe = 1'b1;
            nx.i2c    = S_ACKC;
            commit    = st.sh == REG_COMMIT;
          end else begin
            nx.sda_oe = 1'b1;
            nx.i2c    = S_ACKC;
            wr_pres   = st.ptr == REG_PRESCALE;
            wr_span   = st.ptr == REG_SPAN_GATE;
          end
        end
      end
      S_ACKA: begin
        if (fall && st.rw) begin
          nx.sh     = rd_byte;
          nx.sda_oe = ~rd_byte[7];
          nx.i2c    = S_RD;
        end else if (fall) begin
          nx.sda_oe = 1'b0;
          nx.i2c    = S_CMD;
        end
      end
      S_ACKC: begin
        if (fall) begin
          nx.sda_oe = 1'b0;
          nx.i2c    = S_DATA;
        end
      end
      S_RD: begin
        if (fall && st.bitc == 4'h7) begin
          nx.sda_oe = 1'b0;
          nx.bitc   = 4'h0;
          nx.i2c    = S_RACK;
        end else if (fall) begin
          nx.bitc   = st.bitc + 4'h1;
          nx.sh     = {st.sh[6:0], 1'b0};
          nx.sda_oe = ~st.sh[6];
        end
      end
      S_RACK: begin
        if (rise) begin
          nx.rw = sda_in;  // High means the host declined more
        end else if (fall && st.rw) begin
          nx.i2c = S_IDLE;
        end else if (fall) begin
          nx.sh     = rd_byte;
          nx.sda_oe = ~rd_byte[7];
          nx.i2c    = S_RD;
        end
      end
      default: begin
        nx.i2c    = S_IDLE;
        nx.sda_oe = 1'b0;
      end
    endcase
    if (start) begin
      nx.i2c    = S_ADDR;
      nx.bitc   = 4'h0;
      nx.sda_oe = 1'b0;
    end else if (stop) begin
      nx.i2c    = S_IDLE;
      nx.sda_oe = 1'b0;
    end

    // Register writes and storage requests
    if (wr_pres) begin
      nx.pres      = st.sh;
      nx.pres.rsvd = 1'b0;
    end
    if (wr_span) begin
      nx.span      = st.sh;
      nx.span.rsvd = 1'b0;
    end
    nx.nv_write = commit | wr_span
                | (wr_pres & ~st.span.nv_write_defer);

    // Divider, start-up hold and synchronous gate
    if (!power_down_pin_n_in) begin
      nx.div_cnt  = 8'h00;
      nx.phase    = 1'b0;
      nx.run      = 1'b0;
      nx.boot_cnt = 11'h000;
      nx.booted   = 1'b0;
    end else begin
      nx.div_cnt = st.div_cnt + 8'h01;
      if (!st.booted) begin
        nx.boot_cnt = st.boot_cnt + 11'h001;
        nx.booted   = st.boot_cnt == 11'(STARTUP_CLK - 1);
      end
      if (tick) begin
        nx.phase = ~st.phase;
      end
      if (tick && !st.phase) begin
        nx.run = active;
      end
    end
    nx.clk_pin    = nx.run & nx.phase;
    nx.clk_pin_oe = nx.run | nx.pres.idle_output_level;

    // Triangle dither offset, 1/256 percent units before span scaling
    if (!dith_on) begin
      nx.dcnt = 5'h00;
      nx.dph  = 9'h000;
      nx.doff = '0;
    end else begin
      nx.dcnt = (st.dcnt == lim) ? 5'h00 : st.dcnt + 5'h01;
      nx.dph  = (st.dcnt == lim) ? st.dph + 9'h001 : st.dph;
      // Next span used so the offset never outruns the new bound
      nx.doff = (OFFSET_W'({tri_v, 1'b0}) - OFFSET_W'(255))
                <<< {nx.span.dither_span_hi, nx.span.dither_span_lo};
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st            <= '0;
      st.pres       <= PRESCALE_RST;
      st.span       <= SPAN_GATE_RST;
      st.i2c        <= S_IDLE;
      st.scl_q      <= 1'b1;
      st.sda_q      <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from the state register, except sda_out tied low
  assign sda_out           = 1'b0;
  assign sda_oe_out        = st.sda_oe;
  assign nv_image_out      = {st.pres, st.span};
  assign nv_write_out      = st.nv_write;
  assign clk_pin_out       = st.clk_pin;
  assign clk_pin_oe_out    = st.clk_pin_oe;
  assign dither_offset_out = st.doff;

  // Rule checks on what this block drives
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  a_no_dither_off: assert property (!dith_on |=>
    dither_offset_out == '0)
    else $error("dither offset nonzero while dither is off");
  a_rsvd_zero: assert property (!nv_image_out.pres.rsvd
    && !nv_image_out.span.rsvd) else $error("reserved bit set");
  a_strobe_once: assert property (nv_write_out |=> !nv_write_out)
    else $error("storage strobe longer than one cycle");
  a_quiet_idle: assert property (st.i2c == S_IDLE |-> !sda_oe_out)
    else $error("data line pulled while idle");
  a_dither_bound: assert property ((dither_offset_out <= (12'sd255 <<< span))
    && (dither_offset_out >= -(12'sd255 <<< span)))
    else $error("dither offset beyond span");
  a_idle_level: assert property (!power_down_pin_n_in |=>
    !clk_pin_out && clk_pin_oe_out == st.pres.idle_output_level)
    else $error("power-down output level wrong");
  a_exp_clamp: assert property (st.pres.prescale_exp > EXP_MAX
    |-> mask == 8'hFF) else $error("divider exponent not clamped");
  a_gate_blocks: assert property (!active && tick && !st.phase
    |=> !st.run && !clk_pin_out)
    else $error("output runs while gated off");
  a_span_store: assert property (wr_span |=> nv_write_out &&
    nv_image_out.span.slave_sel == $past(st.sh[2:0]))
    else $error("span write not stored");
  a_defer_hold: assert property (wr_pres && st.span.nv_write_defer
    |=> !nv_write_out) else $error("deferred write was stored");
  a_commit_store: assert property (commit |=> nv_write_out)
    else $error("commit command not stored");
  a_addr_match: assert property (st.i2c == S_ACKA
    |-> st.sh[3:1] == st.span.slave_sel) else $error("wrong address ack");
  a_boot_hold: assert property (!st.booted |-> ##1 !st.run)
    else $error("output ran before start-up count");
  a_sync_start: assert property ($rose(st.run) |-> clk_pin_out
    && $past(tick) && !$past(st.phase))
    else $error("enable not taken at divider phase");

  // Main scenarios reached
  c_commit:  cover property (commit);
  c_defer:   cover property (wr_pres && st.span.nv_write_defer);
  c_dither:  cover property (dith_on ##1 dither_offset_out != '0);
  c_enable:  cover property ($rose(st.run));
  c_readout: cover property (st.i2c == S_RD);

endmodule

// *** tb/scc_i2c_host.sv ***
module scc_i2c_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // Wait of four clocks, one SCL high phase, keeps SCL halves above the minimum
  task automatic wt();
    repeat (4) @(negedge clk_in);
  endtask

  // Start: data falls while the clock is high
  task automatic start();
    sda_low_out = 1'b1;
    wt();
    scl_out = 1'b0;
    wt();
  endtask

  // Byte out MSB first; data moves only well after SCL is low
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = ~b[i];
      wt();
      scl_out = 1'b1;
      wt();
      scl_out = 1'b0;
      wt();
    end
    sda_low_out = 1'b0;
    wt();
    scl_out = 1'b1;
    wt();
    ack = ~sda_in;
    scl_out = 1'b0;
    wt();
  endtask

  // Byte in MSB first; ninth bit pulled low to ask for more
  task automatic recv(input logic more, output logic [7:0] b);
    sda_low_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      wt();
      scl_out = 1'b1;
      wt();
      b[i] = sda_in;
      scl_out = 1'b0;
    end
    wt();
    sda_low_out = more;
    wt();
    scl_out = 1'b1;
    wt();
    scl_out = 1'b0;
    wt();
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    sda_low_out = 1'b1;
    wt();
    scl_out = 1'b1;
    wt();
    sda_low_out = 1'b0;
    wt();
  endtask
endmodule

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scc_pkg::*;

  localparam logic [3:0] ADDR_HI = 4'h5;  // Arbitrary value
  logic                       clk_sys_in = 1'b0;
  logic                       reset_n_in = 1'b0;
  logic                       oe_pin     = 1'b0;
  logic                       dith_pin   = 1'b1;
  logic                       pdn_n      = 1'b1;
  logic                       scl;
  logic                       sda_low;
  logic                       sda_oe;
  logic                       sda_o;
  logic                       nv_wr;
  logic                       clk_o;
  logic                       clk_oe;
  logic                       ack;
  wire logic                  sda_w;
  scc_nv_t                    nv_in      = 16'h311A;
  scc_nv_t                    nv_out;
  logic signed [OFFSET_W-1:0] doff;
  logic [2:0]                 sel        = 3'h2;
  logic [19:0]                rows [5]   = '{20'h20001, 20'h22004,
                                             20'h37080, 20'h28100,
                                             20'h2F100};
  int                         failures   = 0;
  int                         num_checks = 0;
  int                         pulses     = 0;
  int                         p0, n, hi, lo, pk;

  always #2 clk_sys_in = ~clk_sys_in;

  // Open-drain data line with pull-up
  assign sda_w = !(sda_low || (sda_oe && !sda_o));

  scc_config_regs #(.SLAVE_ADDR_HI(ADDR_HI)) uut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .dither_enable_pin_in(dith_pin), .output_enable_pin_in(oe_pin),
    .power_down_pin_n_in(pdn_n), .nv_image_in(nv_in),
    .nv_image_out(nv_out), .nv_write_out(nv_wr), .clk_pin_out(clk_o),
    .clk_pin_oe_out(clk_oe), .dither_offset_out(doff));

  scc_i2c_host host (.clk_in(clk_sys_in), .sda_in(sda_w),
    .scl_out(scl), .sda_low_out(sda_low));

  // Count storage strobes
  always @(posedge clk_sys_in)
    if (nv_wr === 1'b1) pulses <= pulses + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Serial write with ack and strobe-count checks
  task automatic wrc(input logic [7:0] ptr, d, input logic nd,
                     input int np);
    logic a1, a2, a3;
    p0 = pulses;
    a3 = 1'b1;
    host.start();
    host.send({ADDR_HI, sel, 1'b0}, a1);
    host.send(ptr, a2);
    if (nd) host.send(d, a3);
    host.stop();
    check(a1 & a2 & a3, 1'b1);
    check(pulses - p0, np);
  endtask

  // Serial read of two bytes at the current pointer, acked then not
  task automatic rdc(input logic [7:0] exp);
    logic       a1;
    logic [7:0] b0, b1;
    host.start();
    host.send({ADDR_HI, sel, 1'b1}, a1);
    host.recv(1'b1, b0);
    host.recv(1'b0, b1);
    host.stop();
    check(a1, 1'b1);
    check({b0, b1}, {exp, exp});
  endtask

  // Clocks until the output reaches a level, bounded
  task automatic wait_lvl(input logic v, output int c);
    c = 0;
    while (clk_o !== v && c < 3000) begin
      @(negedge clk_sys_in);
      c++;
    end
  endtask

  initial begin
    #300000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (4) @(negedge clk_sys_in);
    check(nv_out, 16'h0000);
    check({clk_o, clk_oe, nv_wr}, 16'h0);
    reset_n_in = 1'b1;
    @(negedge clk_sys_in);
    check(nv_out, 16'h210A);
    wait_lvl(1'b1, n);
    check(n >= 1022 && n <= 1040, 1'b1);
    wrc(REG_SPAN_GATE, 8'h02, 1'b1, 1);
    // Divider table, with write strobe and reserved bit dropped
    foreach (rows[i]) begin
      wrc(REG_PRESCALE, rows[i][19:12], 1'b1, 1);
      check(nv_out.pres, rows[i][19:12] & 8'hEF);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
      check(n, rows[i][11:0]);
    end
    check(doff, 16'h0);
    // Unselected slave address is not acknowledged
    host.start();
    host.send({ADDR_HI, 3'h3, 1'b0}, ack);
    check(ack, 1'b0);
    host.stop();
    dith_pin = 1'b0;
    wrc(REG_SPAN_GATE, 8'h4D, 1'b1, 1);
    sel = 3'h5;
    wrc(REG_PRESCALE, 8'hA1, 1'b1, 0);
    wrc(REG_COMMIT, 8'h00, 1'b0, 1);
    check(nv_out, 16'hA14D);
    lo = 0;
    repeat (300) begin
      @(negedge clk_sys_in);
      if (doff !== '0) lo++;
    end
    check(lo, 0);
    // Full sweep at rate 2, span code 1
    dith_pin = 1'b1;
    hi = 0;
    lo = 0;
    pk = 0;
    repeat (9000) begin
      @(negedge clk_sys_in);
      if (doff > hi) hi = doff;
      if (doff < lo) lo = doff;
      if (doff == 12'sd510) pk++;
    end
    check(hi > 255 && hi <= 510, 1'b1);
    check(hi + lo, 0);
    // Peak held two steps of 16 clocks at rate code 2
    check(pk, 32);
    // Software gate off, pin enable low, then pin high
    wrc(REG_SPAN_GATE, 8'h6D, 1'b1, 1);
    repeat (20) @(negedge clk_sys_in);
    lo = 0;
    repeat (100) begin
      @(negedge clk_sys_in);
      if (clk_o !== 1'b0) lo++;
    end
    check(lo, 0);
    oe_pin = 1'b1;
    wait_lvl(1'b1, n);
    check(n <= 10, 1'b1);
    pdn_n = 1'b0;
    @(negedge clk_sys_in);
    check({clk_o, clk_oe}, 16'h1);
    wrc(REG_PRESCALE, 8'h91, 1'b1, 0);
    check({clk_o, clk_oe}, 16'h0);
    // Hold power-down past 10 us plus two output periods
    repeat (2600) @(negedge clk_sys_in);
    pdn_n = 1'b1;
    wait_lvl(1'b1, n);
    check(n >= 1022 && n <= 1040, 1'b1);
    check(clk_oe, 1'b1);
    // Read back, reserved bit dropped, pointer kept between bytes
    rdc(8'h81);
    wrc(REG_SPAN_GATE, 8'h00, 1'b0, 0);
    rdc(8'h6D);
    wrap_up();
  end
endmodule
